// ### hw/otpep_pkg.sv
// Package: constants and carriers for the one-time-programmable memory programming port
package otpep_pkg;
  localparam int          OTPEP_ADDR_W      = 17;
  localparam int          OTPEP_DATA_W      = 8;
  localparam int          OTPEP_DEPTH       = 131072;
  localparam logic [7:0]  OTPEP_BLANK_BYTE  = 8'hFF;
  localparam logic [16:0] OTPEP_TOP_ADDR    = 17'h1_FFFF;
  localparam logic [16:0] OTPEP_START_64K   = 17'h1_0000;
  localparam logic [16:0] OTPEP_START_48K   = 17'h1_4000;
  localparam logic [23:0] OTPEP_CPU_BASE_64K = 24'hFF_0000;
  localparam logic [23:0] OTPEP_CPU_BASE_48K = 24'hFF_4000;
  localparam logic [23:0] OTPEP_MIRROR_LO   = 24'h00_4000;
  localparam logic [23:0] OTPEP_MIRROR_HI   = 24'h00_FFFF;
  localparam logic [7:0]  OTPEP_BANK_FF     = 8'hFF;
  localparam logic [7:0]  OTPEP_BANK_00     = 8'h00;
  localparam logic        OTPEP_BIT_BLANK   = 1'b1;

  // Programmer-side pins after synchronisation
  typedef struct packed {
    logic [16:0] addr;
    logic [7:0]  data;
    logic        chip_en_n;
    logic        out_en_n;
    logic        prog_n;
    logic        vpp;
  } otpep_pins_t;

  typedef enum logic [1:0] {OTPEP_IDLE, OTPEP_READ, OTPEP_PROG} otpep_state_e_t;
endpackage

// ### hw/otpep_port.sv
// Parallel programming port and CPU read path of the one-time-programmable memory
`timescale 1ns/10ps
`default_nettype none
module otpep_port
  import otpep_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic        eprom_mode_in,
  input  wire logic        mask_variant_in,
  input  wire logic        size_64k_in,
  input  wire logic [7:0]  low_address_port_in,
  input  wire logic [7:0]  mid_address_port_in,
  input  wire logic        top_address_port_bit_in,
  input  wire logic [7:0]  data_port_in,
  input  wire logic        chip_enable_n_in,
  input  wire logic        read_strobe_port_pin_in,
  input  wire logic        write_strobe_port_pin_in,
  input  wire logic        program_voltage_mode_pin_in,
  input  wire logic [23:0] cpu_addr_in,
  input  wire logic        cpu_rd_in,
  output logic [7:0]       data_port_out,
  output logic [7:0]       data_port_oe_out,
  output logic [7:0]       cpu_data_out,
  output logic             cpu_hit_out
);
  otpep_pins_t    raw_pins;
  otpep_pins_t    sync1_reg;
  otpep_pins_t    pins_reg;
  logic           prog_n_d_reg;
  otpep_state_e_t state_reg;
  // Shipped parts are blank, so every bit starts at one
  logic [7:0]     mem [OTPEP_DEPTH] = '{default: OTPEP_BLANK_BYTE};
  logic           active;
  logic           prog_edge;
  logic [7:0]     data_port_reg;
  logic [7:0]     data_oe_reg;
  logic [7:0]     cpu_data_reg;
  logic           cpu_hit_reg;
  logic [17:0]    cpu_map;
  logic [16:0]    cpu_index;
  logic           cpu_in_rom;

  // Map a CPU address onto a memory index, flag whether it lands in ROM
  function automatic logic [17:0] cpu_to_index(input logic [23:0] a, input logic big);
    logic [23:0] base;
    logic        hit;
    base = big ? OTPEP_CPU_BASE_64K : OTPEP_CPU_BASE_48K;
    hit  = 1'b0;
    if (a[23:16] == OTPEP_BANK_FF && a >= base) begin
      hit = 1'b1;
    end else if (a[23:16] == OTPEP_BANK_00 && a >= OTPEP_MIRROR_LO && a <= OTPEP_MIRROR_HI) begin
      // Mirror stays 48K on the 64K part too; its lowest 16K shows in bank FF only
      hit = 1'b1;
    end
    return {hit, 1'b1, a[15:0]};
  endfunction

  assign raw_pins = '{addr: {top_address_port_bit_in, mid_address_port_in, low_address_port_in},
                      data: data_port_in, chip_en_n: chip_enable_n_in,
                      out_en_n: read_strobe_port_pin_in, prog_n: write_strobe_port_pin_in,
                      vpp: program_voltage_mode_pin_in};

  // Programmer pins are asynchronous to this clock
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      sync1_reg    <= '{addr: '0, data: '0, chip_en_n: 1'b1, out_en_n: 1'b1, prog_n: 1'b1, vpp: 1'b0};
      pins_reg     <= '{addr: '0, data: '0, chip_en_n: 1'b1, out_en_n: 1'b1, prog_n: 1'b1, vpp: 1'b0};
      prog_n_d_reg <= 1'b1;
    end else begin
      sync1_reg    <= raw_pins;
      pins_reg     <= sync1_reg;
      prog_n_d_reg <= pins_reg.prog_n;
    end
  end

  assign active    = eprom_mode_in && !mask_variant_in;
  assign prog_edge = active && pins_reg.vpp && !pins_reg.chip_en_n && prog_n_d_reg
                     && !pins_reg.prog_n;

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      state_reg <= OTPEP_IDLE;
    end else if (!active || pins_reg.chip_en_n) begin
      state_reg <= OTPEP_IDLE;
    end else if (pins_reg.vpp) begin
      state_reg <= OTPEP_PROG;
    end else if (!pins_reg.out_en_n) begin
      state_reg <= OTPEP_READ;
    end else begin
      state_reg <= OTPEP_IDLE;
    end
  end

  // Only clears bits: AND of old contents with the pattern; blank is all ones
  always_ff @(posedge clk_in) begin
    if (prog_edge) begin
      mem[pins_reg.addr] <= mem[pins_reg.addr] & pins_reg.data;
    end
  end

  // Plain stored byte on reads; no identification decode at any address
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      data_port_reg <= '0;
      data_oe_reg   <= '0;
    end else begin
      data_port_reg <= mem[pins_reg.addr];
      data_oe_reg   <= (active && !pins_reg.chip_en_n && !pins_reg.out_en_n && !pins_reg.vpp)
                       ? 8'hFF : 8'h00;
    end
  end

  assign cpu_map    = cpu_to_index(cpu_addr_in, size_64k_in);
  assign cpu_index  = cpu_map[16:0];
  assign cpu_in_rom = cpu_map[17];

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cpu_data_reg <= OTPEP_BLANK_BYTE;
      cpu_hit_reg  <= 1'b0;
    end else begin
      cpu_data_reg <= mem[cpu_index];
      cpu_hit_reg  <= cpu_rd_in && cpu_in_rom && !eprom_mode_in;
    end
  end

  assign data_port_out    = data_port_reg;
  assign data_port_oe_out = data_oe_reg;
  assign cpu_data_out     = cpu_data_reg;
  assign cpu_hit_out      = cpu_hit_reg;

  sequence read_setup_s;
    active && !pins_reg.chip_en_n && !pins_reg.out_en_n && !pins_reg.vpp;
  endsequence

  sequence prog_setup_s;
    active && !pins_reg.chip_en_n && pins_reg.vpp;
  endsequence

  // Strobe fall seen under program voltage
  sequence prog_fall_s;
    prog_setup_s ##0 (prog_n_d_reg && !pins_reg.prog_n);
  endsequence

  read_drive_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    read_setup_s |=> data_oe_reg == 8'hFF) else $error("Read not driven");

  no_drive_prog_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    pins_reg.vpp |=> data_oe_reg == 8'h00) else $error("Driven during programming");

  mask_silent_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    mask_variant_in |=> data_oe_reg == 8'h00) else $error("Mask part answered");

  bits_clear_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    prog_edge ##1 !prog_edge |=> (data_port_reg & ~$past(data_port_reg, 1)) == 8'h00
      || $changed(pins_reg.addr)) else $error("Bit returned to one");

  mode_idle_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !active |=> state_reg == OTPEP_IDLE) else $error("State left idle outside mode");

  mirror_hit_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    cpu_rd_in && !eprom_mode_in && cpu_addr_in[23:16] == OTPEP_BANK_00
      && cpu_addr_in[15:14] != 2'b00 |=> cpu_hit_reg) else $error("Mirror miss");

  map_hit_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    cpu_rd_in && !eprom_mode_in && cpu_addr_in[23:16] == OTPEP_BANK_FF
      && cpu_addr_in[15:14] != 2'b00 |=> cpu_hit_reg) else $error("Program area miss");

  low_bank_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    cpu_addr_in[23:14] == 10'h000 |=> !cpu_hit_reg) else $error("Mirror too large");

  write_once_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    prog_fall_s |=> !prog_edge) else $error("Second write from one strobe");

  clear_only_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    prog_fall_s |=> (mem[$past(pins_reg.addr)] & ~$past(pins_reg.data)) == 8'h00)
    else $error("Pattern zero left set");

  no_write_off_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !active |-> !prog_edge) else $error("Write outside programming mode");

  prog_state_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    prog_setup_s |=> state_reg == OTPEP_PROG) else $error("Programming state missed");

  read_state_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    read_setup_s |=> state_reg == OTPEP_READ) else $error("Read state missed");

  read_data_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    read_setup_s |=> data_port_reg == mem[$past(pins_reg.addr)]) else $error("Read not stored");

  release_quiet_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    pins_reg.chip_en_n |=> data_oe_reg == 8'h00) else $error("Driven while deselected");

  cpu_quiet_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    eprom_mode_in |=> !cpu_hit_reg) else $error("CPU hit in programming mode");

  cpu_data_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    cpu_rd_in && !eprom_mode_in |=> cpu_data_reg == mem[$past(cpu_index)])
    else $error("CPU read not stored byte");

  fence_48k_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !size_64k_in && cpu_addr_in[23:14] == 10'h3FC |=> !cpu_hit_reg) else $error("48K fence");

  fence_64k_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    cpu_rd_in && !eprom_mode_in && size_64k_in && cpu_addr_in[23:14] == 10'h3FC
      |=> cpu_hit_reg) else $error("64K low area miss");

  oe_whole_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    data_oe_reg == 8'hFF || data_oe_reg == 8'h00) else $error("Partial data drive");
endmodule
`default_nettype wire

// ### sim/otpep_prog_model.sv
// Parallel programmer model that drives the memory programming pins
`timescale 1ns/10ps
`default_nettype none
module otpep_prog_model (
  input  wire logic        clk_in,
  input  wire logic [7:0]  dev_data_in,
  input  wire logic [7:0]  dev_oe_in,
  output logic      [16:0] addr_out,
  output logic      [7:0]  data_out,
  output logic             ce_n_out,
  output logic             oe_n_out,
  output logic             pgm_n_out,
  output logic             vpp_out
);
  logic [7:0] drv;
  // Resolved data wire; released bus shows inverse of last value
  assign data_out = (dev_oe_in & dev_data_in) | (~dev_oe_in & drv);
  initial begin
    {addr_out, drv} = 25'h0_0000;
    {ce_n_out, oe_n_out, pgm_n_out, vpp_out} = 4'h_E;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // Option bytes use the same write; zero only where a resistor is wanted
  task automatic write_byte(input logic [16:0] a, input logic [7:0] d);
    addr_out = a;
    drv = d;
    ce_n_out = 1'b0;
    vpp_out = 1'b1;
    step(1);
    pgm_n_out = 1'b0;
    step(4);
    pgm_n_out = 1'b1;
    step(4);
    {vpp_out, ce_n_out} = 2'h1;
    drv = ~d;
    step(1);
  endtask
  task automatic read_byte(input logic [16:0] a, output logic [7:0] d, oe);
    addr_out = a;
    {ce_n_out, oe_n_out} = 2'h0;
    step(6);
    d = data_out;
    oe = dev_oe_in;
    {ce_n_out, oe_n_out} = 2'h3;
    step(4);
  endtask
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench for the programming port and CPU read path
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk_in = 0, rstn_in = 0, mode = 1, mask = 0, s64 = 0, c_rd = 0, c_hit;
  logic [23:0] c_addr = 0;
  logic [16:0] p_a;
  logic [7:0]  p_d, d_out, d_oe, c_data, rd, oe;
  logic        ce_n, oe_n, pgm_n, vpp;
  int n_mismatch = 0, cmp_count = 0;
  always #50 clk_in = ~clk_in;
  otpep_prog_model pm (.clk_in(clk_in), .dev_data_in(d_out), .dev_oe_in(d_oe), .addr_out(p_a),
    .data_out(p_d), .ce_n_out(ce_n), .oe_n_out(oe_n), .pgm_n_out(pgm_n), .vpp_out(vpp));
  otpep_port dut (.clk_in(clk_in), .rstn_in(rstn_in), .eprom_mode_in(mode),
    .mask_variant_in(mask), .size_64k_in(s64), .low_address_port_in(p_a[7:0]),
    .mid_address_port_in(p_a[15:8]), .top_address_port_bit_in(p_a[16]), .data_port_in(p_d),
    .chip_enable_n_in(ce_n), .read_strobe_port_pin_in(oe_n), .write_strobe_port_pin_in(pgm_n),
    .program_voltage_mode_pin_in(vpp), .cpu_addr_in(c_addr), .cpu_rd_in(c_rd),
    .data_port_out(d_out), .data_port_oe_out(d_oe), .cpu_data_out(c_data), .cpu_hit_out(c_hit));
  task automatic check(input string name, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cpu_read(input logic [23:0] a, input logic hit, input logic [7:0] dat);
    @(posedge clk_in);
    #1;
    c_addr = a;
    c_rd = 1'b1;
    @(posedge clk_in);
    #1;
    c_rd = 1'b0;
    check("cpu_hit", c_hit, hit);
    if (hit) check("cpu_data", c_data, dat);
  endtask
  // Blank reads all ones; two patterns AND down to zero
  task automatic t_prog;
    logic [16:0] tbl [3] = '{17'h1_4000, 17'h1_FFFF, 17'h1_0000};
    pm.read_byte(17'h1_8000, rd, oe);
    check("blank_data", rd, 8'hFF);
    foreach (tbl[i]) begin
      pm.write_byte(tbl[i], 8'hA5);
      pm.write_byte(tbl[i], 8'h5A);
      pm.read_byte(tbl[i], rd, oe);
      check("prog_data", rd, 8'h00);
      check("prog_oe", oe, 8'hFF);
    end
    // Reset pin pull-up on; vacant bits 7, 5 and 0 kept at one
    pm.write_byte(17'h0_0000, 8'hBF);
    pm.read_byte(17'h0_0000, rd, oe);
    check("option_data", rd, 8'hBF);
  endtask
  task automatic t_refuse;
    cpu_read(24'hFF_4000, 1'b0, 8'h00);
    mask = 1'b1;
    pm.read_byte(17'h1_4000, rd, oe);
    check("mask_oe", oe, 8'h00);
    mask = 1'b0;
  endtask
  task automatic t_cpu;
    mode = 1'b0;
    cpu_read(24'hFF_4000, 1'b1, 8'h00);
    cpu_read(24'hFF_FFFF, 1'b1, 8'h00);
    cpu_read(24'hFF_8000, 1'b1, 8'hFF);
    cpu_read(24'h00_4000, 1'b1, 8'h00);
    cpu_read(24'h00_FFFF, 1'b1, 8'h00);
    cpu_read(24'h00_3FFF, 1'b0, 8'h00);
    cpu_read(24'hFF_0000, 1'b0, 8'h00);
    s64 = 1'b1;
    cpu_read(24'hFF_0000, 1'b1, 8'h00);
    cpu_read(24'h00_3FFF, 1'b0, 8'h00);
  endtask
  initial begin
    repeat (6) @(posedge clk_in);
    #1 rstn_in = 1'b1;
    t_prog();
    t_refuse();
    t_cpu();
    test_done();
  end
  initial begin
    #200000;
    n_mismatch++;
    test_done();
  end
endmodule
`default_nettype wire
